// *** logic/ifd_consts.vh ***
// Constants for the instruction field decoder and sequencer
//
// Summary of operation
// RULE1 - Op 0 copies source location to destination, accumulator untouched.
// RULE2 - Op 1 adds source data to R0 and stores sum at destination.
// RULE3 - Op 2 ANDs source data with R0, result to destination.
// RULE4 - Op 3 XORs source data with R0, result to destination.
// RULE5 - Op 4 executes one instruction addressed by source data combined with literal.
// RULE6 - Op 5 branches on non-zero source data, else program counter plus one.
// RULE7 - Op 6 sends the literal to the destination location.
// RULE8 - Op 7 loads address register and program counter with 13-bit address.
// RULE9 - ALU second operand always comes from accumulator register R0.
// RULE10 - Source high bit zero selects internal register by low four bits.
// RULE11 - Source high bit one reads bus; next bit bank, low three rotate.
// RULE12 - Register-to-register uses R/L as right rotation, no masking.
// RULE13 - Destination R7 or R17 stores result and outputs it as address.
// RULE14 - Literal transmit to R12/R13 drives bus data, registers unchanged.
// RULE15 - Destination high bit zero selects register; R10 never written.
// RULE16 - Destination high bit one selects bus; bank bit, three-bit left shift.
// RULE17 - Bus source or destination makes R/L a field length.
// RULE18 - Bus-to-register passes low length bits of rotated data, rest zero.
// RULE19 - Register-to-bus field has length L, LSB at destination shift.
// RULE20 - Bus-to-bus applies one length to mask and merge.
// RULE21 - Other instructions load incremented PC into address register and PC.
// RULE22 - Execute-out-of-sequence replaces low 5 or 8 address bits, PC kept.
// RULE23 - Taken branch loads low 5 or 8 bits of both from literal.
// RULE24 - Length zero means a full 8-bit field.
// RULE25 - Bank subfield 2 is left bank, 3 is right bank.
// RULE26 - Overflow register R10 updates on every add.
// RULE27 - Each instruction is fetched as one 16-bit word.
// RULE28 - Op code is the top three bits; the rest split per format.
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH

`define IFD_OP_MOVE 3'h0
`define IFD_OP_ADD 3'h1
`define IFD_OP_AND 3'h2
`define IFD_OP_XOR 3'h3
`define IFD_OP_OOS_EXEC 3'h4
`define IFD_OP_NZ_BRANCH 3'h5
`define IFD_OP_LIT_SEND 3'h6
`define IFD_OP_ABS_JUMP 3'h7

`define IFD_BANK_LEFT 2'h2
`define IFD_BANK_RIGHT 2'h3
`define IFD_IDX_ADDR_L 4'h7
`define IFD_IDX_OVERFLOW 4'h8
`define IFD_IDX_DATA_L 4'hA
`define IFD_IDX_DATA_R 4'hB
`define IFD_IDX_ADDR_R 4'hF

`define IFD_ST_IDLE 5'h01
`define IFD_ST_FETCH 5'h02
`define IFD_ST_INPUT 5'h04
`define IFD_ST_EXEC 5'h08
`define IFD_ST_OUTPUT 5'h10

`define IFD_SYNC_WAIT 2'h3

`define IFD_REG_CTRL 12'h000
`define IFD_REG_STATUS 12'h004
`define IFD_REG_ADDR 12'h008
`define IFD_REG_INSTR 12'h00C
`define IFD_REG_FILE 6'h01
`define IFD_CTRL_RESET 32'h00000000

`endif

// *** logic/ifd_sequencer.v ***
// Instruction field decoder, data path and next-address sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ifd_consts.vh"

module ifd_sequencer (
  input wire pclk, // 125 MHz clock
  input wire presetn, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg [12:0] prog_addr, // Program memory address
  input wire [15:0] prog_data, // Program memory word
  input wire [7:0] iv_data_in, // Vector bus data in
  output reg [7:0] iv_data_out, // Vector bus data out
  output reg iv_data_oe_n, // Vector bus drive, low drives
  output reg iv_bank, // 0 left bank, 1 right bank
  output reg select_command_line, // High: bus carries address
  output reg write_strobe // High: bus carries data
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [7:0] ror8;
    input [7:0] v;
    input [2:0] n;
    ror8 = (v >> n) | (v << (4'h8 - {1'b0, n}));
  endfunction

  function [7:0] rol8;
    input [7:0] v;
    input [2:0] n;
    rol8 = (v << n) | (v >> (4'h8 - {1'b0, n}));
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [4:0] state;
  reg [1:0] cnt;
  reg [15:0] instr;
  reg [12:0] pc;
  reg [7:0] iv_lat;
  reg run;
  reg [15:0] prog_s1;
  reg [15:0] prog_s2;
  reg [7:0] iv_s1;
  reg [7:0] iv_s2;
  wire [127:0] file_flat;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [2:0] op = instr[15:13]; // RULE28
  wire [4:0] sfld = instr[12:8]; // RULE28
  wire [2:0] rl = instr[7:5]; // RULE28
  wire [4:0] dfld = instr[4:0]; // RULE28
  wire is_alu = ~op[2];
  wire is_lit_send = (op == `IFD_OP_LIT_SEND);
  wire is_abs_jump = (op == `IFD_OP_ABS_JUMP);
  // Literal transmit carries its destination where other classes carry the source
  wire src_bus = sfld[4] & ~is_lit_send & ~is_abs_jump; // RULE11
  wire dst_bus = is_alu ? dfld[4] : (is_lit_send & sfld[4]); // RULE16
  wire dst_reg = is_alu ? ~dfld[4] : (is_lit_send & ~sfld[4]); // RULE15
  wire [4:0] dsel = is_alu ? dfld : sfld;
  wire [3:0] dst_idx = dsel[3:0]; // RULE15
  wire [2:0] dst_sh = dsel[2:0]; // RULE16
  wire dst_right = (dsel[4:3] == `IFD_BANK_RIGHT); // RULE25
  wire src_right = (sfld[4:3] == `IFD_BANK_RIGHT); // RULE25
  wire in_right = src_bus ? src_right : dst_right;
  wire lit_short = src_bus | (is_lit_send & sfld[4]);
  wire [7:0] literal = lit_short ? {3'h0, instr[4:0]} : instr[7:0];

  // Length zero spans the whole byte
  wire [7:0] len_mask = (rl == 3'h0) ? 8'hFF : ~(8'hFF << rl); // RULE24 RULE17

  // ----------------------------------------------------------------
  // Source and ALU
  // ----------------------------------------------------------------
  wire [7:0] reg_src = file_flat[{sfld[3:0], 3'h0} +: 8]; // RULE10
  wire [7:0] acc = file_flat[7:0]; // RULE9
  wire rr_form = is_alu & ~sfld[4] & ~dfld[4]; // RULE12
  reg [7:0] src_val;
  reg [8:0] alu;

  always @* begin
    if (src_bus) begin
      src_val = ror8(iv_lat, sfld[2:0]) & len_mask; // RULE11 RULE18 RULE20
    end else if (rr_form) begin
      src_val = ror8(reg_src, rl); // RULE12
    end else begin
      src_val = reg_src; // RULE10
    end
  end

  always @* begin
    case (op)
      `IFD_OP_MOVE: alu = {1'b0, src_val}; // RULE1
      `IFD_OP_ADD: alu = {1'b0, src_val} + {1'b0, acc}; // RULE2 RULE9
      `IFD_OP_AND: alu = {1'b0, src_val & acc}; // RULE3 RULE9
      `IFD_OP_XOR: alu = {1'b0, src_val ^ acc}; // RULE4 RULE9
      `IFD_OP_OOS_EXEC: alu = {1'b0, src_val} + {1'b0, literal}; // RULE5
      `IFD_OP_LIT_SEND: alu = {1'b0, literal}; // RULE7
      default: alu = {1'b0, src_val};
    endcase
  end

  // Field lands at the shift position; bits outside it keep bus data
  wire [7:0] field_mask = rol8(len_mask, dst_sh); // RULE19 RULE20
  wire [7:0] merged = (iv_lat & ~field_mask) | rol8(alu[7:0] & len_mask, dst_sh); // RULE19

  wire nz_taken = (op == `IFD_OP_NZ_BRANCH) && (src_val != 8'h00); // RULE6
  wire is_addr_dst = dst_reg &
    ((dst_idx == `IFD_IDX_ADDR_L) || (dst_idx == `IFD_IDX_ADDR_R)); // RULE13
  wire is_lit_data = is_lit_send & dst_reg &
    ((dst_idx == `IFD_IDX_DATA_L) || (dst_idx == `IFD_IDX_DATA_R)); // RULE14
  wire exec = (state == `IFD_ST_EXEC);
  wire reg_we = exec & dst_reg & (dst_idx != `IFD_IDX_OVERFLOW) & ~is_lit_data; // RULE15 RULE14
  wire ovf_we = exec & (op == `IFD_OP_ADD); // RULE26

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_reg
      reg [7:0] r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          r <= 8'h00;
        end else if (gi == 8) begin
          if (ovf_we) begin
            r <= {7'h00, alu[8]}; // RULE26
          end
        end else if (reg_we && dst_idx == gi) begin
          r <= alu[7:0]; // RULE1 RULE2 RULE3 RULE4 RULE7 RULE13
        end
      end
      assign file_flat[gi*8 +: 8] = r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_s1 <= 16'h0000;
      prog_s2 <= 16'h0000;
      iv_s1 <= 8'h00;
      iv_s2 <= 8'h00;
    end else begin
      prog_s1 <= prog_data;
      prog_s2 <= prog_s1;
      iv_s1 <= iv_data_in;
      iv_s2 <= iv_s1;
    end
  end

  // ----------------------------------------------------------------
  // Instruction cycle sequencer
  // ----------------------------------------------------------------
  // Fetch and input each wait out the synchroniser before sampling, so external
  // memory gets three clocks to settle and bus devices one clock after the bank is set.
  wire [12:0] pc_inc = pc + 13'h0001;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= `IFD_ST_IDLE;
      cnt <= 2'h0;
      instr <= 16'h0000;
      pc <= 13'h0000;
      prog_addr <= 13'h0000;
      iv_lat <= 8'h00;
      iv_data_out <= 8'h00;
      iv_data_oe_n <= 1'b1;
      iv_bank <= 1'b0;
      select_command_line <= 1'b0;
      write_strobe <= 1'b0;
    end else begin
      case (state)
        `IFD_ST_IDLE: begin
          cnt <= 2'h0;
          if (run) begin
            state <= `IFD_ST_FETCH;
          end
        end
        `IFD_ST_FETCH: begin
          if (cnt == `IFD_SYNC_WAIT) begin
            instr <= prog_s2; // RULE27
            cnt <= 2'h0;
            state <= `IFD_ST_INPUT;
          end else begin
            cnt <= cnt + 2'h1;
          end
        end
        `IFD_ST_INPUT: begin
          // Bank is set for both bus sources and merge destinations
          iv_bank <= in_right; // RULE25
          if (cnt == `IFD_SYNC_WAIT) begin
            iv_lat <= iv_s2;
            cnt <= 2'h0;
            state <= `IFD_ST_EXEC;
          end else begin
            cnt <= cnt + 2'h1;
          end
        end
        `IFD_ST_EXEC: begin
          state <= `IFD_ST_OUTPUT;
          if (is_abs_jump) begin
            prog_addr <= instr[12:0]; // RULE8
            pc <= instr[12:0]; // RULE8
          end else if (op == `IFD_OP_OOS_EXEC) begin
            if (src_bus) begin
              prog_addr <= {pc[12:5], alu[4:0]}; // RULE22
            end else begin
              prog_addr <= {pc[12:8], alu[7:0]}; // RULE22
            end
          end else if (nz_taken) begin
            if (lit_short) begin
              prog_addr <= {pc[12:5], instr[4:0]}; // RULE23
              pc <= {pc[12:5], instr[4:0]}; // RULE23
            end else begin
              prog_addr <= {pc[12:8], instr[7:0]}; // RULE23
              pc <= {pc[12:8], instr[7:0]}; // RULE23
            end
          end else begin
            prog_addr <= pc_inc; // RULE21 RULE6
            pc <= pc_inc; // RULE21 RULE6
          end
          if (is_addr_dst) begin
            iv_data_out <= alu[7:0]; // RULE13
            iv_bank <= dst_idx[3];
            iv_data_oe_n <= 1'b0;
            select_command_line <= 1'b1; // RULE13
          end else if (is_lit_data) begin
            iv_data_out <= alu[7:0]; // RULE14
            iv_bank <= dst_idx[0];
            iv_data_oe_n <= 1'b0;
            write_strobe <= 1'b1; // RULE14
          end else if (dst_bus) begin
            iv_data_out <= merged; // RULE16 RULE19 RULE20
            iv_bank <= dst_right; // RULE25
            iv_data_oe_n <= 1'b0;
            write_strobe <= 1'b1;
          end
        end
        `IFD_ST_OUTPUT: begin
          iv_data_oe_n <= 1'b1;
          select_command_line <= 1'b0;
          write_strobe <= 1'b0;
          state <= run ? `IFD_ST_FETCH : `IFD_ST_IDLE;
        end
        default: begin
          state <= `IFD_ST_IDLE;
          cnt <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle, which keeps
  // every bus output registered.
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite & pready;
  wire in_file = (paddr[11:6] == `IFD_REG_FILE);
  reg [31:0] rd_mux;
  reg rd_err;

  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (in_file) begin
      rd_mux = {24'h000000, file_flat[{paddr[5:2], 3'h0} +: 8]};
    end else begin
      case (paddr)
        `IFD_REG_CTRL: rd_mux = {31'h00000000, run};
        `IFD_REG_STATUS: rd_mux = {11'h000, state, 3'h0, pc};
        `IFD_REG_ADDR: rd_mux = {19'h00000, prog_addr};
        `IFD_REG_INSTR: rd_mux = {16'h0000, instr};
        default: rd_err = 1'b1;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      run <= 1'b0;
    end else begin
      pready <= apb_acc & ~pready;
      if (apb_acc & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= pwrite ? (paddr != `IFD_REG_CTRL) : rd_err;
      end else begin
        pslverr <= 1'b0;
      end
      // Clearing run lets the current instruction finish before idling
      if (apb_wr && paddr == `IFD_REG_CTRL) begin
        run <= pwdata[0];
      end
    end
  end

endmodule
`default_nettype wire

// *** test/ifd_far_side.sv ***
// Far side model: program memory and two vector bus devices
`timescale 1ns/1ps
`default_nettype none
module ifd_far_side (
  input wire logic pclk, // Clock
  input wire logic [12:0] prog_addr, // Program address
  output logic [15:0] prog_data, // Instruction word
  output logic [7:0] iv_data_in, // Bus data to device
  input wire logic [7:0] iv_data_out, // Bus data from device
  input wire logic iv_data_oe_n, // Low while device drives
  input wire logic iv_bank, // Bank select
  input wire logic select_command_line, // Address phase
  input wire logic write_strobe // Data phase
);
  logic [15:0] mem [0:8191];
  logic [7:0] bank_l, bank_r, dev_addr;
  assign prog_data = mem[prog_addr];
  // Devices let go while the sequencer drives, so the input shows no stale byte
  assign iv_data_in = !iv_data_oe_n ? ~iv_data_out : (iv_bank ? bank_r : bank_l);
  always @(posedge pclk) begin
    if (!iv_data_oe_n && select_command_line)
      dev_addr <= iv_data_out;
    if (!iv_data_oe_n && write_strobe && iv_bank)
      bank_r <= iv_data_out;
    if (!iv_data_oe_n && write_strobe && !iv_bank)
      bank_l <= iv_data_out;
  end
endmodule
`default_nettype wire

// *** test/ifd_seq_props.sv ***
// Port-level checks for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module ifd_seq_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [12:0] prog_addr, // Program address
  input wire logic [7:0] iv_data_out, // Bus data out
  input wire logic iv_data_oe_n, // Low while bus is driven
  input wire logic iv_bank, // Bus bank
  input wire logic select_command_line, // Address phase
  input wire logic write_strobe // Data phase
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_drive_once: assert property ($fell(iv_data_oe_n) |=> iv_data_oe_n)
    else $error("bus driven too long");
  chk_drive_cause: assert property (!iv_data_oe_n |-> select_command_line ^ write_strobe)
    else $error("bus driven without one strobe");
  chk_strobe_drives: assert property (select_command_line || write_strobe |-> !iv_data_oe_n)
    else $error("strobe without drive");
  // Peripherals latch late in the cycle, so data must not move between drives
  chk_data_hold: assert property (iv_data_oe_n |-> $stable(iv_data_out))
    else $error("bus data moved while idle");
  // Bank may leave the input bank as the drive starts, but holds through the latching edge
  chk_bank_steady: assert property (!iv_data_oe_n |=> $stable(iv_bank))
    else $error("bank moved at end of drive");
  chk_fetch_spacing: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*8])
    else $error("fetch address moved too soon");
  chk_out_advances: assert property ($fell(iv_data_oe_n) |-> $changed(prog_addr))
    else $error("address not advanced at output");
  cover property (select_command_line);
  cover property (write_strobe);
  cover property (pslverr);
endmodule
bind ifd_sequencer ifd_seq_props i_props (.pclk, .presetn, .pready, .pslverr, .prog_addr,
  .iv_data_out, .iv_data_oe_n, .iv_bank, .select_command_line, .write_strobe);
`default_nettype wire

// *** test/test_instruction_field_decode_and_sequencer.sv ***
// Self-checking bench: register bus access and a short random program
`timescale 1ns/1ps
`default_nettype none
module test_instruction_field_decode_and_sequencer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic iv_data_oe_n, iv_bank, select_command_line, write_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [31:0] rv [16];
  logic [12:0] prog_addr;
  logic [15:0] prog_data;
  logic [7:0] iv_data_in, iv_data_out, a, b, c, lb, rb, m;
  logic [2:0] r, src_rot, dst_sft;
  int err_total, samples_checked, n, len;
  ifd_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .prog_addr, .prog_data, .iv_data_in, .iv_data_out, .iv_data_oe_n,
    .iv_bank, .select_command_line, .write_strobe);
  ifd_far_side i_far (.pclk, .prog_addr, .prog_data, .iv_data_in, .iv_data_out,
    .iv_data_oe_n, .iv_bank, .select_command_line, .write_strobe);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  function automatic logic [7:0] ror(input logic [7:0] v, input logic [2:0] k);
    return (v >> k) | (v << (4'd8 - k));
  endfunction
  function automatic logic [15:0] ins(input logic [2:0] o, input logic [4:0] s,
      input logic [7:0] j);
    return {o, s, j};
  endfunction
  task automatic report_and_stop();
    $display("Mismatches %0d, checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int k);
    if (k >= 999) begin
      err_total++;
      $display("FAIL t=%0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 999) begin
      @(posedge pclk);
      n++;
    end
    guard(n);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    st = 32'd59;
    err_total = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    // ---------------------------------------------
    // Random operands, program and bank contents
    // ---------------------------------------------
    a = 8'(rnd()) | 8'h01;
    b = 8'(rnd());
    c = 8'(rnd());
    lb = 8'(rnd());
    rb = 8'(rnd());
    r = 3'(rnd());
    src_rot = 3'(rnd());
    len = int'(rnd() % 8) + 1;
    dst_sft = 3'(rnd() % (9 - len));
    m = 8'hFF >> (8 - len);
    i_far.bank_l = lb;
    i_far.bank_r = rb;
    i_far.mem[0] = ins(3'h6, 5'h01, a);
    i_far.mem[1] = ins(3'h6, 5'h00, b);
    i_far.mem[2] = ins(3'h1, 5'h01, {r, 5'h02});
    i_far.mem[3] = ins(3'h2, 5'h01, 8'h03);
    i_far.mem[4] = ins(3'h3, 5'h01, 8'h04);
    i_far.mem[5] = ins(3'h0, 5'h01, 8'h07);
    i_far.mem[6] = ins(3'h0, {2'h2, src_rot}, {3'(len), 5'h05});
    i_far.mem[7] = ins(3'h0, 5'h01, {3'(len), 2'h3, dst_sft});
    i_far.mem[8] = ins(3'h6, 5'h0A, c);
    i_far.mem[9] = ins(3'h0, 5'h01, 8'h08);
    i_far.mem[10] = ins(3'h5, 5'h01, 8'h20);
    i_far.mem[13'h020] = {3'h7, 13'h0100};
    i_far.mem[13'h100] = ins(3'h4, 5'h06, 8'h40);
    i_far.mem[13'h140] = ins(3'h6, 5'h06, 8'h5A);
    // Second leg: untaken branch, right-bank data, R17 address, short-form targets
    i_far.mem[13'h101] = ins(3'h5, 5'h09, 8'h55);
    i_far.mem[13'h102] = ins(3'h6, 5'h0B, 8'hC3);
    i_far.mem[13'h103] = ins(3'h0, 5'h02, 8'h0F);
    i_far.mem[13'h104] = ins(3'h5, 5'h18, 8'h10);
    i_far.mem[13'h110] = ins(3'h4, 5'h18, 8'h15);
    i_far.mem[13'h118] = ins(3'h6, 5'h09, 8'h77);
    i_far.mem[13'h111] = {3'h7, 13'h0111};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h800, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h004, 32'h3);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h000, 32'h1);
    chk({31'h0, e}, 32'h0);
    n = 0;
    while (prog_addr !== 13'h0101 && n < 999) begin
      @(posedge pclk);
      n++;
    end
    guard(n);
    chk({19'h0, prog_addr}, 32'h101);
    chk(i_far.dev_addr, a);
    chk(i_far.bank_r, (rb & ~(m << dst_sft)) | ((a & m) << dst_sft));
    chk(i_far.bank_l, c);
    n = 0;
    while (prog_addr !== 13'h0111 && n < 999) begin
      @(posedge pclk);
      n++;
    end
    guard(n);
    repeat (22) @(posedge pclk);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 12'h040 + 12'(4 * i), 32'h0);
      rv[i] = q;
    end
    chk({rv[1][7:0], rv[0][7:0]}, {16'h0, a, b});
    chk(rv[2], 8'(ror(a, r) + b));
    chk(rv[3], a & b);
    chk(rv[4], a ^ b);
    chk(rv[5], ror(lb, src_rot) & m);
    chk(rv[6], 32'h5A);
    chk(rv[7], a);
    chk(rv[8], (ror(a, r) + b) >> 8);
    chk(rv[10] | rv[11], 32'h0);
    chk(rv[9], 32'h00000077);
    chk(rv[15], 8'(ror(a, r) + b));
    chk(i_far.dev_addr, 8'(ror(a, r) + b));
    chk(i_far.bank_r, 32'h000000C3);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h00000111);
    report_and_stop();
  end
endmodule
`default_nettype wire
